// ===== core/dps_pkg.sv
// shared constants and types of the dual loop status and powerdown block
package dps_pkg;

    // serial word layout
    localparam int WORD_W = 22;
    localparam int DATA_W = 20;
    localparam int SEL_W  = 2;

    // latch select codes carried in the last two serial bits
    localparam logic [1:0] SEL_REF_TWO = 2'h0;
    localparam logic [1:0] SEL_REF_ONE = 2'h1;
    localparam logic [1:0] SEL_FB_TWO  = 2'h2;
    localparam logic [1:0] SEL_FB_ONE  = 2'h3;

    // bit positions inside the 20 stored data bits of a reference word
    localparam int POS_POLARITY = 15;
    localparam int POS_PUMP_MAG = 16;
    localparam int POS_PUMP_HIZ = 17;
    localparam int POS_LOCK_SEL = 18;
    localparam int POS_DIV_SEL  = 19;

    // bit positions inside the 20 stored data bits of a feedback word
    localparam int POS_PRESCALER = 18;
    localparam int POS_PWDN      = 19;

    // reset value of every latched word
    localparam logic [19:0] WORD_RESET = 20'h0_0000;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_REF_TWO = 8'h00;
    localparam logic [7:0] OFS_REF_ONE = 8'h04;
    localparam logic [7:0] OFS_FB_TWO  = 8'h08;
    localparam logic [7:0] OFS_FB_ONE  = 8'h0C;
    localparam logic [7:0] OFS_STATUS  = 8'h10;

    // function currently shown on the status pin
    typedef enum logic [2:0] {
        PIN_OFF   = 3'b000,
        PIN_LOCK  = 3'b001,
        PIN_REF   = 3'b010,
        PIN_FB    = 3'b011,
        PIN_ACCEL = 3'b100,
        PIN_RESET = 3'b101
    } dps_pin_mode_t;

    // powerdown sequencer states
    typedef enum logic [1:0] {
        PWR_ACTIVE  = 2'b00,
        PWR_PENDING = 2'b01,
        PWR_DOWN    = 2'b10
    } dps_pwr_state_t;

endpackage

// ===== core/dps_load_if.sv
// carrier for a latched serial word between receiver and control core
`timescale 1ns/100ps
interface dps_load_if;
    logic [19:0] data;
    logic [1:0]  sel;
    logic        strobe;

    modport src (output data, output sel, output strobe);
    modport dst (input data, input sel, input strobe);
endinterface

// ===== core/dps_ser_rx.sv
// three-wire serial receiver sampled on the system clock
`timescale 1ns/100ps
module dps_ser_rx (
    // clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // serial pins
    input  wire logic   ser_clk,
    input  wire logic   ser_data,
    input  wire logic   load_enable,
    // latched word out
    dps_load_if.src     load
);
    logic [2:0]  clk_s;
    logic [2:0]  le_s;
    logic [1:0]  dat_s;
    logic [21:0] shift;

    // stage 0 feeds only stage 1; edges are found on stages 1 and 2
    wire clk_rise = clk_s[1] & ~clk_s[2];
    wire le_rise  = le_s[1] & ~le_s[2];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_s <= 3'h0;
            le_s  <= 3'h0;
            dat_s <= 2'h0;
        end
        else
        begin
            clk_s <= {clk_s[1:0], ser_clk};
            le_s  <= {le_s[1:0], load_enable};
            dat_s <= {dat_s[0], ser_data};
        end
    end

    // msb first, shifting on every rising serial clock, never gated
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shift <= 22'h00_0000;
        else if (clk_rise)
            shift <= {shift[20:0], dat_s[1]};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            load.data   <= 20'h0_0000;
            load.sel    <= 2'h0;
            load.strobe <= 1'b0;
        end
        else
        begin
            load.strobe <= le_rise;
            if (le_rise)
            begin
                load.data <= shift[21:2];
                load.sel  <= shift[1:0];
            end
        end
    end
endmodule

// ===== core/dps_pwr_seq.sv
// per-loop powerdown sequencer
`timescale 1ns/100ps
module dps_pwr_seq (
    // clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // latched mode bits
    input  wire logic   pwdn_bit,
    input  wire logic   pump_hiz_bit,
    // synchronised charge pump idle indication
    input  wire logic   pump_idle,
    // state
    output logic        powered_down,
    output logic        sync_pending
);
    dps_pkg::dps_pwr_state_t state;
    dps_pkg::dps_pwr_state_t next_state;

    always_comb
    begin
        next_state = state;
        case (state)
            dps_pkg::PWR_ACTIVE:
                if (pwdn_bit && pump_hiz_bit)
                    next_state = dps_pkg::PWR_DOWN;
                else if (pwdn_bit)
                    next_state = dps_pkg::PWR_PENDING;
            dps_pkg::PWR_PENDING:
                if (!pwdn_bit)
                    next_state = dps_pkg::PWR_ACTIVE;
                else if (pump_idle)
                    next_state = dps_pkg::PWR_DOWN;
            dps_pkg::PWR_DOWN:
                if (!pwdn_bit)
                    next_state = dps_pkg::PWR_ACTIVE;
            default:
                next_state = dps_pkg::PWR_ACTIVE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= dps_pkg::PWR_ACTIVE;
        else
            state <= next_state;
    end

    assign powered_down = (state == dps_pkg::PWR_DOWN);
    assign sync_pending = (state == dps_pkg::PWR_PENDING);

    // waiting on the pump, the loop stays up
    property p_sync_wait;
        @(posedge pclk) disable iff (!presetn)
        (state == dps_pkg::PWR_PENDING) && pwdn_bit && !pump_idle
            |=> (state == dps_pkg::PWR_PENDING);
    endproperty
    a_sync_wait: assert property (p_sync_wait)
        else $error("sync powerdown left before pump went idle");
endmodule

// ===== core/dps_status_ctrl.sv
// dual loop status pin decode, counter reset and powerdown control
`timescale 1ns/100ps
module dps_status_ctrl (
    // clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // register bus
    input  wire logic [7:0]     paddr,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    // serial load pins
    input  wire logic           ser_clk,
    input  wire logic           ser_data,
    input  wire logic           load_enable,
    // loop indications, bit 0 loop one, bit 1 loop two
    input  wire logic [1:0]     lock_raw,
    input  wire logic [1:0]     ref_div_raw,
    input  wire logic [1:0]     fb_div_raw,
    input  wire logic [1:0]     pump_idle_raw,
    // multipurpose status pin
    output logic                status_pin_o,
    output logic                status_pin_oe,
    // loop controls
    output logic      [1:0]     counter_reset,
    output logic      [1:0]     pump_hiz,
    output logic      [1:0]     pump_boost,
    output logic      [1:0]     divider_load,
    output logic      [1:0]     rf_input_hiz,
    output logic      [1:0]     loop_powered_down,
    output logic      [1:0]     phase_polarity,
    output logic      [1:0]     prescaler_select,
    output logic                osc_enable
);
    dps_load_if load ();

    dps_ser_rx u_rx (
        .pclk        (pclk),
        .presetn     (presetn),
        .ser_clk     (ser_clk),
        .ser_data    (ser_data),
        .load_enable (load_enable),
        .load        (load)
    );

    // two-stage synchronisers for the asynchronous loop indications
    logic [7:0] ind_s1;
    logic [7:0] ind_s2;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ind_s1 <= 8'h00;
            ind_s2 <= 8'h00;
        end
        else
        begin
            ind_s1 <= {pump_idle_raw, fb_div_raw, ref_div_raw, lock_raw};
            ind_s2 <= ind_s1;
        end
    end

    wire [1:0] lock_s = ind_s2[1:0];
    wire [1:0] ref_s  = ind_s2[3:2];
    wire [1:0] fb_s   = ind_s2[5:4];
    wire [1:0] idle_s = ind_s2[7:6];

    // latched words; index 0 is loop one, index 1 loop two
    logic [1:0][19:0] ref_word;
    logic [1:0][19:0] fb_word;

    wire apb_wr = psel & penable & pwrite;

    wire [1:0] ser_ref = {load.strobe && (load.sel == dps_pkg::SEL_REF_TWO),
                          load.strobe && (load.sel == dps_pkg::SEL_REF_ONE)};
    wire [1:0] ser_fb  = {load.strobe && (load.sel == dps_pkg::SEL_FB_TWO),
                          load.strobe && (load.sel == dps_pkg::SEL_FB_ONE)};
    wire [1:0] apb_ref = {apb_wr && (paddr == dps_pkg::OFS_REF_TWO),
                          apb_wr && (paddr == dps_pkg::OFS_REF_ONE)};
    wire [1:0] apb_fb  = {apb_wr && (paddr == dps_pkg::OFS_FB_TWO),
                          apb_wr && (paddr == dps_pkg::OFS_FB_ONE)};

    // a serial load wins over a bus write landing in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_word <= {2{dps_pkg::WORD_RESET}};
            fb_word  <= {2{dps_pkg::WORD_RESET}};
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (ser_ref[i])
                    ref_word[i] <= load.data;
                else if (apb_ref[i])
                    ref_word[i] <= pwdata[19:0];
                if (ser_fb[i])
                    fb_word[i] <= load.data;
                else if (apb_fb[i])
                    fb_word[i] <= pwdata[19:0];
            end
        end
    end

    // mode bits straight from the latched words
    wire [1:0] lock_sel = {ref_word[1][dps_pkg::POS_LOCK_SEL],
                           ref_word[0][dps_pkg::POS_LOCK_SEL]};
    wire [1:0] div_sel  = {ref_word[1][dps_pkg::POS_DIV_SEL],
                           ref_word[0][dps_pkg::POS_DIV_SEL]};
    wire [1:0] pump_mag = {ref_word[1][dps_pkg::POS_PUMP_MAG],
                           ref_word[0][dps_pkg::POS_PUMP_MAG]};
    wire [1:0] hiz_bit  = {ref_word[1][dps_pkg::POS_PUMP_HIZ],
                           ref_word[0][dps_pkg::POS_PUMP_HIZ]};
    wire [1:0] pol_bit  = {ref_word[1][dps_pkg::POS_POLARITY],
                           ref_word[0][dps_pkg::POS_POLARITY]};
    wire [1:0] pre_bit  = {fb_word[1][dps_pkg::POS_PRESCALER],
                           fb_word[0][dps_pkg::POS_PRESCALER]};
    wire [1:0] pwdn_bit = {fb_word[1][dps_pkg::POS_PWDN],
                           fb_word[0][dps_pkg::POS_PWDN]};

    // pin function decode, live from latched bits
    wire div_none   = (div_sel == 2'b00);
    wire div_one    = ^div_sel;
    wire div_both   = &div_sel;
    wire pick_two   = div_sel[1];
    wire lock_both  = lock_s[0] & lock_s[1];
    wire lock_view  = (lock_sel == 2'b01) ? lock_s[0] :
                      (lock_sel == 2'b10) ? lock_s[1] : lock_both;
    wire div_view   = lock_sel[1] ? fb_s[pick_two]
                                  : ref_s[pick_two];
    wire accel_mode = div_both && (lock_sel == 2'b00);
    wire ref_pick   = ref_s[pick_two];
    wire fb_pick    = fb_s[pick_two];

    dps_pkg::dps_pin_mode_t pin_mode;
    assign pin_mode = div_none ? ((lock_sel == 2'b00) ? dps_pkg::PIN_OFF
                                                       : dps_pkg::PIN_LOCK) :
                      div_one  ? (lock_sel[1] ? dps_pkg::PIN_FB
                                              : dps_pkg::PIN_REF) :
                      accel_mode ? dps_pkg::PIN_ACCEL : dps_pkg::PIN_RESET;

    wire [1:0] next_boost = accel_mode ? pump_mag : 2'b00;
    // counter reset bits line up with the lock bits: bit 1 loop two
    wire [1:0] next_cnt_rst = (div_both && !accel_mode) ? lock_sel
                                                        : 2'b00;

    wire next_pin_o = (pin_mode == dps_pkg::PIN_LOCK) ? lock_view :
                      (pin_mode == dps_pkg::PIN_REF ||
                       pin_mode == dps_pkg::PIN_FB) ? div_view : 1'b0;
    // acceleration is open drain: only pull low, never drive high
    wire next_pin_oe = (pin_mode == dps_pkg::PIN_ACCEL) ? |next_boost
                                                        : 1'b1;

    // powerdown sequencers
    logic [1:0] pd_down;
    logic [1:0] pd_pend;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_loop
            dps_pwr_seq u_pwr (
                .pclk         (pclk),
                .presetn      (presetn),
                .pwdn_bit     (pwdn_bit[g]),
                .pump_hiz_bit (hiz_bit[g]),
                .pump_idle    (idle_s[g]),
                .powered_down (pd_down[g]),
                .sync_pending (pd_pend[g])
            );
        end
    endgenerate

    // one reset signal per loop feeds both its counters, so they restart
    // on the same clock
    wire [1:0] next_pump_hiz = hiz_bit | next_cnt_rst | pd_down;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_pin_o      <= 1'b0;
            status_pin_oe     <= 1'b1;
            counter_reset     <= 2'b00;
            pump_hiz          <= 2'b00;
            pump_boost        <= 2'b00;
            divider_load      <= 2'b00;
            rf_input_hiz      <= 2'b00;
            loop_powered_down <= 2'b00;
            phase_polarity    <= 2'b00;
            prescaler_select  <= 2'b00;
            osc_enable        <= 1'b1;
        end
        else
        begin
            status_pin_o      <= next_pin_o;
            status_pin_oe     <= next_pin_oe;
            counter_reset     <= next_cnt_rst;
            pump_hiz          <= next_pump_hiz;
            pump_boost        <= next_boost;
            divider_load      <= pd_down;
            rf_input_hiz      <= pd_down;
            loop_powered_down <= pd_down;
            phase_polarity    <= pol_bit;
            prescaler_select  <= pre_bit;
            osc_enable        <= ~(pwdn_bit[0] & pwdn_bit[1]);
        end
    end

    // register bus: data captured in setup, zero-wait access phase
    wire setup   = psel & ~penable;
    wire hit_rt  = (paddr == dps_pkg::OFS_REF_TWO);
    wire hit_ro  = (paddr == dps_pkg::OFS_REF_ONE);
    wire hit_ft  = (paddr == dps_pkg::OFS_FB_TWO);
    wire hit_fo  = (paddr == dps_pkg::OFS_FB_ONE);
    wire hit_st  = (paddr == dps_pkg::OFS_STATUS);
    wire hit_any = hit_rt | hit_ro | hit_ft | hit_fo | hit_st;
    // status is read only, so a write to it is refused
    wire bad_acc = ~hit_any | (hit_st & pwrite);

    wire [31:0] status_word = {19'h0_0000, pin_mode, lock_s, osc_enable,
                               status_pin_o, counter_reset, pd_pend,
                               loop_powered_down};
    wire [31:0] next_rdata = hit_rt ? {12'h000, ref_word[1]} :
                             hit_ro ? {12'h000, ref_word[0]} :
                             hit_ft ? {12'h000, fb_word[1]} :
                             hit_fo ? {12'h000, fb_word[0]} :
                             hit_st ? status_word : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
            if (setup)
            begin
                prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
                pslverr <= bad_acc;
            end
        end
    end

    // checks
    wire [3:0] mode_sel = {lock_sel[0], lock_sel[1], div_sel[0], div_sel[1]};

    property p_pin_off;
        @(posedge pclk) disable iff (!presetn)
        (mode_sel == 4'b0000) |=> status_pin_oe && !status_pin_o;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("disabled status pin not driven low");

    property p_lock_both;
        @(posedge pclk) disable iff (!presetn)
        (mode_sel == 4'b1100) |=> status_pin_o == $past(lock_both);
    endproperty
    a_lock_both: assert property (p_lock_both)
        else $error("combined lock does not need both loops");

    property p_lock_two;
        @(posedge pclk) disable iff (!presetn)
        (mode_sel == 4'b0100) ##1 (mode_sel == 4'b0100)
            |-> status_pin_o == $past(lock_s[1]);
    endproperty
    a_lock_two: assert property (p_lock_two)
        else $error("loop two lock not shown on status pin");

    property p_ref_div;
        @(posedge pclk) disable iff (!presetn)
        (div_one && !lock_sel[1]) |=> status_pin_o == $past(ref_pick);
    endproperty
    a_ref_div: assert property (p_ref_div)
        else $error("reference divider not routed to status pin");

    property p_fb_div;
        @(posedge pclk) disable iff (!presetn)
        (div_one && lock_sel[1]) |=> status_pin_o == $past(fb_pick);
    endproperty
    a_fb_div: assert property (p_fb_div)
        else $error("feedback divider not routed to status pin");

    property p_accel;
        @(posedge pclk) disable iff (!presetn)
        (mode_sel == 4'b0011) && pump_mag[0]
            |=> status_pin_oe && !status_pin_o && pump_boost[0];
    endproperty
    a_accel: assert property (p_accel)
        else $error("acceleration not active with pump magnitude high");

    property p_reset_two;
        @(posedge pclk) disable iff (!presetn)
        (mode_sel == 4'b0111) |=> counter_reset == 2'b10 && pump_hiz[1];
    endproperty
    a_reset_two: assert property (p_reset_two)
        else $error("loop two counter reset mode wrong");

    property p_reset_all;
        @(posedge pclk) disable iff (!presetn)
        (mode_sel == 4'b1111) |=> counter_reset == 2'b11 && pump_hiz == 2'b11;
    endproperty
    a_reset_all: assert property (p_reset_all)
        else $error("both loops not held in counter reset");

    property p_async_down;
        @(posedge pclk) disable iff (!presetn)
        $rose(pwdn_bit[0]) && hiz_bit[0] |-> ##[1:2] loop_powered_down[0];
    endproperty
    a_async_down: assert property (p_async_down)
        else $error("async powerdown of loop one late");

    property p_power_up;
        @(posedge pclk) disable iff (!presetn)
        $fell(pwdn_bit[1]) |-> ##[1:2] !loop_powered_down[1];
    endproperty
    a_power_up: assert property (p_power_up)
        else $error("loop two did not power up");

    property p_osc;
        @(posedge pclk) disable iff (!presetn)
        (pwdn_bit != 2'b11) |=> osc_enable;
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator stopped with one loop still up");

    property p_serial_live;
        @(posedge pclk) disable iff (!presetn)
        load.strobe && (load.sel == dps_pkg::SEL_FB_ONE)
            |=> fb_word[0] == $past(load.data);
    endproperty
    a_serial_live: assert property (p_serial_live)
        else $error("serial word not latched");
endmodule

// ===== testbench/dps_host_model.sv
// host side of the three-wire serial load interface
`timescale 1ns/100ps
module dps_host_model (
    // serial pins
    output logic ser_clk,
    output logic ser_data,
    output logic load_enable
);
    initial
    begin
        ser_clk = 1'h0;
        ser_data = 1'h0;
        load_enable = 1'h0;
    end

    // serial clock stands low between frames; data idles at the inverse
    task automatic send(input logic [1:0] sel, input logic [19:0] d);
        logic [21:0] wd;
        wd = {d, sel};
        for (int i = 21; i >= 0; i--)
        begin
            ser_data <= wd[i];
            #40 ser_clk <= 1'h1;
            #80 ser_clk <= 1'h0;
            #40;
        end
        ser_data <= ~wd[0];
        #40 load_enable <= 1'h1;
        #80 load_enable <= 1'h0;
    endtask
endmodule

// ===== testbench/dps_status_ctrl_tb.sv
// self-checking bench of the status pin and powerdown block
`timescale 1ns/100ps
module dps_status_ctrl_tb;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, d;
    logic        pready, pslverr, ser_clk, ser_data, load_enable;
    logic [1:0]  lock, refd, fbd, idle;
    logic        pin_o, pin_oe, osc;
    logic [1:0]  crst, phiz, boost, dload, rfhiz, pdn, pol, pre;
    logic [18:0] obs;
    logic [19:0] w [4];
    logic [33:0] note_q [$];
    logic [33:0] note;
    logic [32:0] rd_got;
    int          mismatches, samples_checked;
    int          cyc = 0;
    event        res_ev;

    dps_host_model host (.ser_clk(ser_clk), .ser_data(ser_data),
        .load_enable(load_enable));
    dps_status_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ser_clk(ser_clk), .ser_data(ser_data), .load_enable(load_enable),
        .lock_raw(lock), .ref_div_raw(refd), .fb_div_raw(fbd),
        .pump_idle_raw(idle), .status_pin_o(pin_o), .status_pin_oe(pin_oe),
        .counter_reset(crst), .pump_hiz(phiz), .pump_boost(boost),
        .divider_load(dload), .rf_input_hiz(rfhiz),
        .loop_powered_down(pdn), .phase_polarity(pol), .prescaler_select(pre),
        .osc_enable(osc));

    // pin value only matters while it is driven
    assign obs = {pin_oe, pin_o & pin_oe, crst, phiz, boost, pdn, dload,
                  rfhiz, osc, pol, pre};

    always #10 pclk = ~pclk;

    function automatic logic [18:0] exp_obs();
        logic [1:0] ld, fo, pd, cr, bst;
        logic       oe, o;
        ld = {w[0][18], w[1][18]};
        fo = {w[0][19], w[1][19]};
        cr = 2'h0;
        bst = 2'h0;
        oe = 1'h1;
        o = 1'h0;
        pd = {w[2][19] & (w[0][17] | idle[1]), w[3][19] & (w[1][17] | idle[0])};
        if (fo == 2'h0)
            o = (ld == 2'h3) ? &lock : ld[1] ? lock[1] : ld[0] & lock[0];
        else if (fo != 2'h3)
            o = ld[1] ? fbd[fo[1]] : refd[fo[1]];
        else if (ld == 2'h0)
        begin
            bst = {w[0][16], w[1][16]};
            oe = |bst;
        end
        else
            cr = ld;
        return {oe, o & oe, cr, {w[0][17], w[1][17]} | cr | pd, bst, pd, pd, pd,
                ~&{w[2][19], w[3][19]}, {w[0][15], w[1][15]},
                {w[2][18], w[3][18]}};
    endfunction

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h",
                     note[33] ? "read" : "outputs", exp, got);
        end
    endtask

    always @(res_ev)
    begin
        note = note_q.pop_front();
        check(note[33] ? rd_got : {14'h0000, obs}, note[32:0]);
    end

    task automatic expect_now(input logic rd, input logic [32:0] exp);
        note_q.push_back({rd, exp});
        -> res_ev;
        @(posedge pclk);
    endtask

    // no completion flag exists: wait out load latency and input sync
    task automatic expect_obs();
        repeat (12) @(posedge pclk);
        #1;
        expect_now(1'h0, {14'h0000, exp_obs()});
    endtask

    task automatic load(input logic [1:0] sel, input logic [19:0] v);
        host.send(sel, v);
        w[sel] = v;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd_got = {pslverr, prdata};
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic stop_test();
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            stop_test();
        end
    end

    initial
    begin
        {pclk, presetn, psel, penable, pwrite} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        {lock, refd, fbd} = 6'h00;
        idle = 2'h3;
        w = '{default: 20'h0_0000};
        mismatches = 0;
        samples_checked = 0;
        void'($urandom(32'h01b7));
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        expect_obs();
        for (int m = 0; m < 16; m++)
        begin
            load(2'h0, {m[3], m[1], 1'h0, 17'($urandom)});
            load(2'h1, {m[2], m[0], 1'h0, 17'($urandom)});
            repeat (2)
            begin
                @(posedge pclk);
                {lock, refd, fbd} <= 6'($urandom);
                expect_obs();
            end
        end
        load(2'h0, 20'h0_0000);
        load(2'h1, 20'h2_0000);
        expect_obs();
        @(posedge pclk);
        idle <= 2'h0;
        load(2'h3, 20'hC_0000);
        expect_obs();
        load(2'h2, 20'h8_0000);
        expect_obs();
        // loop one down, loop two still waiting on its pump
        apb(1'h0, dps_pkg::OFS_STATUS, 32'h0000_0000);
        expect_now(1'h1, {23'h00_0000, lock, 8'h09});
        @(posedge pclk);
        idle <= 2'h3;
        expect_obs();
        load(2'h3, 20'h0_0000);
        expect_obs();
        for (int i = 0; i < 4; i++)
        begin
            apb(1'h0, 8'(4 * i), 32'h0000_0000);
            expect_now(1'h1, {13'h0000, w[i]});
        end
        d = $urandom;
        apb(1'h1, dps_pkg::OFS_REF_ONE, d);
        w[1] = d[19:0];
        apb(1'h0, dps_pkg::OFS_REF_ONE, 32'h0000_0000);
        expect_now(1'h1, {13'h0000, d[19:0]});
        apb(1'h1, dps_pkg::OFS_FB_TWO, 32'hfff0_0000);
        w[2] = 20'h0_0000;
        expect_obs();
        apb(1'h1, dps_pkg::OFS_STATUS, 32'hffff_ffff);
        expect_now(1'h1, 33'h1_0000_0000);
        apb(1'h0, 8'h14, 32'h0000_0000);
        expect_now(1'h1, 33'h1_0000_0000);
        expect_obs();
        stop_test();
    end
endmodule
